/* File: dv/sicp_host.sv */
// ============================================================
// Host model: an AXI4-Lite master that runs one transfer at a time.
module sicp_host (
   input  wire logic        aclk,
   output logic      [7:0]  s_axi_awaddr,
   output logic      [2:0]  s_axi_awprot,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic      [31:0] s_axi_wdata,
   output logic      [3:0]  s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic      [7:0]  s_axi_araddr,
   output logic      [2:0]  s_axi_arprot,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
      {s_axi_arvalid, s_axi_rready} = '0;
   end

   // Released addresses and data are inverted so that nothing relies on stale values.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr  <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata  <= ~d;
         end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr  <= ~a;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

/* File: dv/test_sensor_info_config_params.sv */
`include "sicp_regs.svh"
`define CHK(g, e) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
   end \
end

module test_sensor_info_config_params
   import sicp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          n_mismatch = 0;
   int          check_count = 0;

   sicp_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   sicp_host host_u (.aclk(aclk), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   // ============================================================
   // Bus helpers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      host_u.wr(a, d, 4'hf, r);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      host_u.rd(a, d, r);
      `CHK(d, e)
   endtask

   task automatic load(input logic [6:0] idx, input logic [31:0] l1);
      wr(`SICP_OFF_INDEX, {25'h0, idx});
      wr(`SICP_OFF_LOAD0, 32'h0c1e02a7);
      wr(`SICP_OFF_LOAD0 + 8'h04, l1);
      wr(`SICP_OFF_LOAD0 + 8'h08, 32'h00c8000c);
      wr(`SICP_OFF_LOAD3, 32'h04000000);
      wr(`SICP_OFF_CMD, 32'h00000002);
   endtask

   // ============================================================
   // Scenarios
   task automatic s_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rd(`SICP_OFF_INDEX, 32'h0);
      for (int k = 0; k < 4; k++) begin
         rd(`SICP_OFF_DESC0 + 8'(4 * k), 32'h0);
      end
      host_u.rd(8'h44, d, r);
      `CHK(r, `SICP_RESP_SLVE)
      `CHK(d, 32'h0)
      host_u.wr(8'h44, 32'hffffffff, 4'hf, r);
      `CHK(r, `SICP_RESP_SLVE)
   endtask

   // Fractional, exact and saturating maximum ranges.
   task automatic s_info;
      logic [31:0] l1 [3] = '{32'h01009cea, 32'h01005000, 32'h01ffff01};
      logic [15:0] mr [3] = '{16'h009d, 16'h0050, 16'hffff};
      for (int k = 0; k < 3; k++) begin
         load(7'h05, l1[k]);
         rd(`SICP_OFF_DESC0, 32'h1e02a715);
         rd(`SICP_OFF_DESC0 + 8'h04, {16'h000c, mr[k]});
         rd(`SICP_OFF_DESC0 + 8'h08, 32'h000000c8);
         rd(`SICP_OFF_DESC3, 32'h010c0400);
      end
      wr(`SICP_OFF_INDEX, 32'h25);
      rd(`SICP_OFF_DESC0, 32'h1e02a725);
   endtask

   // The first three slots are normal, the rest are reserved.
   task automatic s_cfg;
      logic [6:0] ix [8] = '{7'h45, 7'h65, 7'h7f, 7'h40, 7'h5a, 7'h5e, 7'h60, 7'h7e};
      for (int k = 0; k < 8; k++) begin
         wr(`SICP_OFF_INDEX, {25'h0, ix[k]});
         wr(`SICP_OFF_CFGW0, {25'h0, ix[k]});
         wr(`SICP_OFF_CFGW1, {16'h0010, 9'h0, ix[k]});
         wr(`SICP_OFF_CMD, 32'h00000001);
      end
      for (int k = 0; k < 8; k++) begin
         wr(`SICP_OFF_INDEX, {25'h0, ix[k]});
         rd(`SICP_OFF_CFGR0, (k < 3) ? {25'h0, ix[k]} : 32'h0);
         rd(`SICP_OFF_CFGR1, (k < 3) ? {16'h0010, 9'h0, ix[k]} : 32'h0);
      end
      wr(`SICP_OFF_INDEX, 32'h5a);
      rd(`SICP_OFF_STATUS, 32'h0000035a);
      wr(`SICP_OFF_INDEX, 32'h05);
      rd(`SICP_OFF_DESC0 + 8'h04, 32'h000cffff);
      rd(`SICP_OFF_CFGR0, 32'h0);
   endtask

   task automatic s_drop;
      wr(`SICP_OFF_INDEX, 32'h45);
      rd(`SICP_OFF_DESC0, 32'h0);
      wr(`SICP_OFF_INDEX, 32'h05);
      wr(`SICP_OFF_CMD, 32'h00000004);
      for (int k = 0; k < 4; k++) begin
         rd(`SICP_OFF_DESC0 + 8'(4 * k), 32'h0);
      end
      // Load and drop together: the load wins and the id is supported again.
      wr(`SICP_OFF_CMD, 32'h00000006);
      rd(`SICP_OFF_STATUS, 32'h00000c05);
      rd(`SICP_OFF_DESC0, 32'h1e02a715);
   endtask

   // ============================================================
   // Run control
   task automatic stop_test;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      aclk = 1'b0;
   end

   always #4 aclk = ~aclk;

   initial begin
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset();
      s_info();
      s_cfg();
      s_drop();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      stop_test();
   end
endmodule

/* File: logic/sicp_fmt.sv */
`include "sicp_regs.svh"

module sicp_fmt
   import sicp_pkg::*;
(
   input  wire logic [6:0]   idx,
   input  wire logic         sup,
   input  wire sicp_info_t   info,
   output logic      [127:0] rec
);

   // ============================================================
   // Description record assembly, little-endian 16-bit fields.
   logic [7:0] type_echo;

   always_comb begin
      type_echo = {2'b00, idx[5:0]};
      if (!idx[`SICP_IDX_WAKE_BIT]) begin
         type_echo[`SICP_TYPE_NWK_BIT] = 1'b1;
      end
   end

   always_comb begin
      rec = '0;
      if (sup && !idx[`SICP_IDX_CFG_BIT]) begin
         rec[7:0]     = type_echo;
         rec[31:8]    = {info.pwr, info.ver, info.drv};
         rec[47:32]   = info.rng;
         rec[63:48]   = info.res;
         rec[79:64]   = info.maxr;
         rec[95:80]   = info.fres;
         rec[111:96]  = info.fmax;
         rec[119:112] = info.evsz;
         rec[127:120] = info.minr;
      end
   end

endmodule

/* File: logic/sicp_mem.sv */
module sicp_mem #(
   parameter int W     = 64,
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic          aclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);

   logic [W-1:0] mem [DEPTH];

   if (DEPTH != (1 << AW) || W < 1) begin : g_bad
      $error("sicp_mem: DEPTH must equal 2**AW and W be positive.");
   end

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge aclk) begin
      rdata <= mem[raddr];
   end

endmodule

/* File: logic/sicp_pkg.sv */
package sicp_pkg;

   typedef struct packed {
      logic [7:0]  minr;
      logic [7:0]  evsz;
      logic [15:0] fmax;
      logic [15:0] fres;
      logic [15:0] maxr;
      logic [15:0] res;
      logic [15:0] rng;
      logic [7:0]  pwr;
      logic [7:0]  ver;
      logic [7:0]  drv;
   } sicp_info_t;

   typedef struct packed {
      logic [15:0] drng;
      logic [15:0] sens;
      logic [15:0] lat;
      logic [15:0] rate;
   } sicp_cfg_t;

   function automatic logic [31:0] sicp_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

endpackage

/* File: logic/sicp_regs.svh */
// ============================================================
// Overview of operation
// - Index bits select sensor, wakeup, configuration.
// - Unsupported sensor returns all-zero description.
// - Max range is highest-setting sensor range.
// - Max range ignores current dynamic range.
// - Fractional max range rounds up to integer, holding at ffff.
// - Bytes 6-7 report resolution bits.
// - Byte 0 echoes requested sensor type.
// - Type bit 4 set for non-wakeup sensors.
// - Bytes 1-3 driver id, version, power.
// - Max range, max rate, min rate placed.
// - Bytes 10-11 reserved FIFO packets.
// - Bytes 12-13 whole FIFO packets.
// - Byte 14 event size including type.
`ifndef SICP_REGS_SVH
`define SICP_REGS_SVH

// ============================================================
// Register byte offsets
`define SICP_OFF_INDEX  8'h00
`define SICP_OFF_CMD    8'h04
`define SICP_OFF_STATUS 8'h08
`define SICP_OFF_DESC0  8'h10
`define SICP_OFF_DESC3  8'h1c
`define SICP_OFF_CFGW0  8'h20
`define SICP_OFF_CFGW1  8'h24
`define SICP_OFF_CFGR0  8'h28
`define SICP_OFF_CFGR1  8'h2c
`define SICP_OFF_LOAD0  8'h30
`define SICP_OFF_LOAD3  8'h3c

// ============================================================
// Field positions
`define SICP_IDX_WAKE_BIT 5
`define SICP_IDX_CFG_BIT  6
`define SICP_TYPE_NWK_BIT 4
`define SICP_CMD_CFG_BIT  0
`define SICP_CMD_LOAD_BIT 1
`define SICP_CMD_DROP_BIT 2
`define SICP_ST_CFG_BIT   8
`define SICP_ST_RSVD_BIT  9
`define SICP_ST_SUP_BIT   10
`define SICP_ST_CFGV_BIT  11

// ============================================================
// Reset values and answers
`define SICP_RST_INDEX 7'h00
`define SICP_RST_WORD  32'h0000_0000
`define SICP_RESP_OKAY 2'b00
`define SICP_RESP_SLVE 2'b10
`define SICP_RSVD_LO   5'h1a
`define SICP_RSVD_HI   5'h1e

`endif

/* File: logic/sicp_top.sv */
`include "sicp_regs.svh"

module sicp_top
   import sicp_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic      [1:0]  s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic      [31:0] s_axi_rdata,
   output logic      [1:0]  s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ============================================================
   // State
   logic [6:0]   index;
   logic [31:0]  cfgw [2];
   logic [31:0]  load [4];
   logic [31:0]  sup;
   logic [63:0]  cfgv;
   logic         aw_got;
   logic         w_got;
   logic [7:0]   aw_addr;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic [6:0]   idx_q;
   logic         sup_q;
   logic         cfgv_q;
   sicp_info_t   info_q;
   sicp_info_t   info_wdata;
   sicp_cfg_t    cfg_q;
   logic [127:0] rec;
   logic         wr_do;
   logic         cmd_wr;
   logic         cfg_we;
   logic         info_we;
   logic         drop_we;
   logic         rsvd;
   logic         rsvd_q;
   logic [31:0]  rd_word;
   logic         rd_ok;
   logic         wr_ok;
   logic [15:0]  rng_int;
   logic         rng_frac;

   // ============================================================
   // Decode of the selected index.
   always_comb begin
      rsvd = (index[4:0] == 5'h00) ||
             (index[4:0] >= `SICP_RSVD_LO && index[4:0] <= `SICP_RSVD_HI);
   end

   assign wr_do   = aw_got && w_got && !s_axi_bvalid;
   assign cmd_wr  = wr_do && (aw_addr == `SICP_OFF_CMD) && w_strb[0];
   assign cfg_we  = cmd_wr && w_data[`SICP_CMD_CFG_BIT] &&
                    index[`SICP_IDX_CFG_BIT] && !rsvd;
   assign info_we = cmd_wr && w_data[`SICP_CMD_LOAD_BIT];
   assign drop_we = cmd_wr && w_data[`SICP_CMD_DROP_BIT];

   // ============================================================
   // Max range is given with eight fraction bits and rounded up once
   // at load, so later dynamic range changes never touch it.
   assign rng_int  = load[1][23:8];
   assign rng_frac = |load[1][7:0];

   always_comb begin
      info_wdata.drv  = load[0][7:0];
      info_wdata.ver  = load[0][15:8];
      info_wdata.pwr  = load[0][23:16];
      info_wdata.evsz = load[0][31:24];
      info_wdata.minr = load[1][31:24];
      info_wdata.res  = load[2][15:0];
      info_wdata.maxr = load[2][31:16];
      info_wdata.fres = load[3][15:0];
      info_wdata.fmax = load[3][31:16];
      info_wdata.rng  = rng_int;
      if (rng_frac && rng_int != 16'hffff) begin
         info_wdata.rng = 16'(rng_int + 16'h0001);
      end
   end

   sicp_mem #(
      .W     ($bits(sicp_info_t)),
      .DEPTH (32),
      .AW    (5)
   ) u_info (
      .aclk  (aclk),
      .we    (info_we),
      .waddr (index[4:0]),
      .wdata (info_wdata),
      .raddr (index[4:0]),
      .rdata (info_q)
   );

   sicp_mem #(
      .W     ($bits(sicp_cfg_t)),
      .DEPTH (64),
      .AW    (6)
   ) u_cfg (
      .aclk  (aclk),
      .we    (cfg_we),
      .waddr (index[5:0]),
      .wdata ({cfgw[1], cfgw[0]}),
      .raddr (index[5:0]),
      .rdata (cfg_q)
   );

   sicp_fmt u_fmt (
      .idx  (idx_q),
      .sup  (sup_q),
      .info (info_q),
      .rec  (rec)
   );

   // Side flags lag the index by one cycle, like the memory reads, to stay coherent.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idx_q  <= `SICP_RST_INDEX;
         sup_q  <= 1'b0;
         cfgv_q <= 1'b0;
         rsvd_q <= 1'b1;
      end else begin
         idx_q  <= index;
         sup_q  <= sup[index[4:0]];
         cfgv_q <= cfgv[index[5:0]];
         rsvd_q <= rsvd;
      end
   end

   // ============================================================
   // Support and configuration valid masks.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sup <= '0;
      end else if (info_we) begin
         sup[index[4:0]] <= 1'b1;
      end else if (drop_we) begin
         sup[index[4:0]] <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfgv <= '0;
      end else if (cfg_we) begin
         cfgv[index[5:0]] <= 1'b1;
      end
   end

   // ============================================================
   // Software registers.
   always_comb begin
      wr_ok = (aw_addr <= `SICP_OFF_LOAD3) && (aw_addr[1:0] == 2'b00) &&
              !(aw_addr > `SICP_OFF_STATUS && aw_addr < `SICP_OFF_DESC0);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         index <= `SICP_RST_INDEX;
      end else if (wr_do && aw_addr == `SICP_OFF_INDEX && w_strb[0]) begin
         index <= w_data[6:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfgw[0] <= `SICP_RST_WORD;
         cfgw[1] <= `SICP_RST_WORD;
         for (int i = 0; i < 4; i++) begin
            load[i] <= `SICP_RST_WORD;
         end
      end else if (wr_do) begin
         if (aw_addr == `SICP_OFF_CFGW0) begin
            cfgw[0] <= sicp_strb(cfgw[0], w_data, w_strb);
         end
         if (aw_addr == `SICP_OFF_CFGW1) begin
            cfgw[1] <= sicp_strb(cfgw[1], w_data, w_strb);
         end
         if (aw_addr >= `SICP_OFF_LOAD0 && aw_addr <= `SICP_OFF_LOAD3) begin
            load[aw_addr[3:2]] <= sicp_strb(load[aw_addr[3:2]], w_data, w_strb);
         end
      end
   end

   // ============================================================
   // Write channels: address and data taken in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_got        <= 1'b0;
         aw_addr       <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_got        <= 1'b1;
         aw_addr       <= s_axi_awaddr;
      end else if (wr_do) begin
         aw_got <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_got        <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_got        <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
      end else if (wr_do) begin
         w_got <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SICP_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `SICP_RESP_OKAY : `SICP_RESP_SLVE;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ============================================================
   // Read channel: data sampled at the address handshake.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         `SICP_OFF_INDEX:  rd_word = {25'h0000000, index};
         `SICP_OFF_CMD:    rd_word = 32'h0000_0000;
         `SICP_OFF_STATUS: rd_word = {20'h00000, cfgv_q, sup_q, rsvd_q,
                                      idx_q[`SICP_IDX_CFG_BIT], 1'b0, idx_q};
         8'h10:            rd_word = rec[31:0];
         8'h14:            rd_word = rec[63:32];
         8'h18:            rd_word = rec[95:64];
         `SICP_OFF_DESC3:  rd_word = rec[127:96];
         `SICP_OFF_CFGW0:  rd_word = cfgw[0];
         `SICP_OFF_CFGW1:  rd_word = cfgw[1];
         `SICP_OFF_CFGR0,
         `SICP_OFF_CFGR1: begin
            if (idx_q[`SICP_IDX_CFG_BIT] && !rsvd_q && cfgv_q) begin
               rd_word = s_axi_araddr[2] ? {cfg_q.drng, cfg_q.sens}
                                         : {cfg_q.lat, cfg_q.rate};
            end
         end
         8'h30:            rd_word = load[0];
         8'h34:            rd_word = load[1];
         8'h38:            rd_word = load[2];
         `SICP_OFF_LOAD3:  rd_word = load[3];
         default:          rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `SICP_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? `SICP_RESP_OKAY : `SICP_RESP_SLVE;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ============================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_cfg_route: assert property (cfg_we |-> index[`SICP_IDX_CFG_BIT] && index[4:0] != 5'h00)
      else $error("Configuration written through a non-configuration index.");
   chk_zero_unsup: assert property (!sup_q |-> rec == 128'h0)
      else $error("Unsupported sensor shows a non-zero record.");
   chk_range_whole: assert property (info_we && !rng_frac |=> ##1
                                     !$past(index[4:0] != idx_q[4:0], 2) && sup_q |->
                                     rec[47:32] == $past(rng_int, 2) || idx_q[6])
      else $error("Whole max range altered on load.");
   chk_range_const: assert property (cfg_we && !info_we && !drop_we |=> ##1
                                     $stable(rec[47:32]))
      else $error("Max range moved after a configuration write.");
   chk_range_ceil: assert property (info_we && rng_frac && rng_int != 16'hffff |->
                                    info_wdata.rng == 16'(rng_int + 16'h0001))
      else $error("Fractional max range not rounded up.");
   chk_res_bytes: assert property (sup_q && !idx_q[6] |-> rec[63:48] == info_q.res)
      else $error("Resolution bytes wrong.");
   chk_type_echo: assert property (sup_q && !idx_q[6] |-> rec[5:0] == idx_q[5:0] ||
                                   (!idx_q[5] && rec[3:0] == idx_q[3:0]))
      else $error("Sensor type not echoed.");
   chk_nwk_bit: assert property (sup_q && !idx_q[6] |-> rec[4] == !idx_q[5] || idx_q[4])
      else $error("Non-wakeup type bit wrong.");
   chk_drv_bytes: assert property (sup_q && !idx_q[6] |->
                                   rec[31:8] == {info_q.pwr, info_q.ver, info_q.drv})
      else $error("Driver bytes wrong.");
   chk_rate_bytes: assert property (sup_q && !idx_q[6] |-> rec[79:64] == info_q.maxr
                                    && rec[127:120] == info_q.minr)
      else $error("Rate bytes wrong.");
   chk_fifo_bytes: assert property (sup_q && !idx_q[6] |-> rec[95:80] == info_q.fres
                                    && rec[111:96] == info_q.fmax)
      else $error("FIFO bytes wrong.");
   chk_evsz_byte: assert property (sup_q && !idx_q[6] |-> rec[119:112] == info_q.evsz)
      else $error("Event size byte wrong.");
   chk_rsvd_slot: assert property (cmd_wr && rsvd |-> !cfg_we ##1 !$rose(cfgv[index[5:0]]))
      else $error("Reserved configuration slot accepted a write.");
   chk_bresp_time: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("Write response late.");

endmodule
